// ---- logic/lcd_seg_pkg.sv ----
`default_nettype none
package lcd_seg_pkg;
  // register addresses on the cpu memory map
  localparam logic [15:0] ADDR_DISPLAY_MODE = 16'hFFB0;
  localparam logic [15:0] ADDR_PIN_SELECTOR = 16'hFFB1;
  localparam logic [15:0] ADDR_CLOCK_CTRL   = 16'hFFB2;
  localparam logic [15:0] ADDR_DISP_MEM_LO  = 16'hFA00;
  localparam logic [15:0] ADDR_DISP_MEM_HI  = 16'hFA1B;
  localparam int          DISP_MEM_BYTES    = 28;

  // reset values
  localparam logic [7:0] RST_DISPLAY_MODE = 8'h00;
  localparam logic [7:0] RST_PIN_SELECTOR = 8'h00;
  localparam logic [7:0] RST_CLOCK_CTRL   = 8'h00;

  // display mode register fields
  localparam int BIT_DISPLAY_ENABLE = 7;
  localparam int BIT_LOW_VOLTAGE    = 6;
  localparam int BIT_DRIVE_POWER    = 4;
  localparam int POS_DISPLAY_MODE   = 0;
  // writable bits of each register; the rest read as zero
  localparam logic [7:0] MASK_DISPLAY_MODE = 8'hD7;
  localparam logic [7:0] MASK_PIN_SELECTOR = 8'h3F;
  localparam logic [7:0] MASK_CLOCK_CTRL   = 8'h0F;
  localparam logic [7:0] MASK_DISP_MEM     = 8'h0F;

  // display mode codes
  localparam logic [2:0] MODE_4SLICE_THIRD = 3'h0;
  localparam logic [2:0] MODE_3SLICE_THIRD = 3'h1;
  localparam logic [2:0] MODE_2SLICE_HALF  = 3'h2;
  localparam logic [2:0] MODE_3SLICE_HALF  = 3'h3;
  localparam logic [2:0] MODE_STATIC       = 3'h4;

  // clock control fields
  localparam int POS_SOURCE_SEL = 2;
  localparam int POS_SCAN_DIV   = 0;
  localparam logic [1:0] SRC_MAIN_DIV128 = 2'h0;
  localparam logic [1:0] SRC_SUBSYSTEM   = 2'h1;
  localparam logic [1:0] SRC_MAIN_DIV32  = 2'h2;
  localparam logic [1:0] SRC_MAIN_DIV8   = 2'h3;
  localparam logic [6:0] MAIN_DIV128_MAX = 7'h7F;
  localparam logic [6:0] MAIN_DIV32_MAX  = 7'h1F;
  localparam logic [6:0] MAIN_DIV8_MAX   = 7'h07;
  localparam logic [8:0] SCAN_DIV64_MAX  = 9'h03F;
endpackage
`default_nettype wire

// ---- logic/lcd_segment_controller.sv ----
`default_nettype none
// Contract
// - display off forces all segments deselect
// - mode bit selects normal or low-voltage operation
// - power bit routes drive power to bias
// - mode field decodes slices and bias
// - reset clears all three control registers
// - bit writes and byte writes both accepted
// - selector bits switch segment pairs from ports
// - source field picks main divider or subsystem
// - scan field divides source by 64 to 512
// - frame equals scan clock over slice count
// - 28-byte display memory scanned automatically
// - unscanned low-nibble memory bits act as plain RAM
// - memory upper nibble holds no storage
// - bits 0..3 follow commons 0..3
// - commons scanned in turn, static drives all
module lcd_segment_controller
  import lcd_seg_pkg::*;
#(
  parameter int SEG_COUNT = 28
)(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic [15:0]          cpu_addr,
  input  wire logic [7:0]           cpu_wdata,
  input  wire logic [7:0]           cpu_wmask,
  input  wire logic                 cpu_wr,
  input  wire logic                 cpu_rd,
  output logic      [7:0]           cpu_rdata,
  output logic                      cpu_hit,
  input  wire logic                 subsystem_oscillator_clock,
  output logic      [3:0]           common_select,
  output logic      [SEG_COUNT-1:0] segment_select,
  output logic                      drive_polarity,
  output logic                      bias_third,
  output logic                      static_drive,
  output logic                      low_voltage_mode,
  output logic                      bias_power_on,
  output logic      [5:0]           segment_pin_enable
);

  logic [7:0] display_mode_reg;
  logic [7:0] pin_selector_reg;
  logic [7:0] clock_ctrl_reg;
  logic [3:0] disp_mem [SEG_COUNT];
  logic [7:0] rdata_reg;
  logic       hit_reg;
  logic [2:0] xt_sync_reg;
  logic       xt_level_reg;
  logic [6:0] main_cnt_reg;
  logic [8:0] pre_cnt_reg;
  logic [1:0] slice_reg;
  logic       polarity_reg;
  logic [3:0] com_reg;
  logic [SEG_COUNT-1:0] seg_reg;

  // address decode
  wire        sel_mode  = (cpu_addr == ADDR_DISPLAY_MODE);
  wire        sel_pins  = (cpu_addr == ADDR_PIN_SELECTOR);
  wire        sel_clock = (cpu_addr == ADDR_CLOCK_CTRL);
  wire        sel_mem   = (cpu_addr >= ADDR_DISP_MEM_LO) &&
                          (cpu_addr <= ADDR_DISP_MEM_HI);
  wire [4:0]  mem_index = cpu_addr[4:0];
  wire        any_sel   = sel_mode | sel_pins | sel_clock | sel_mem;

  // merge only the bits named in the write mask
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] wmask,
                                       input logic [7:0] keep);
    merge = ((old_v & ~wmask) | (new_v & wmask)) & keep;
  endfunction

  // control fields
  wire        display_on = display_mode_reg[BIT_DISPLAY_ENABLE];
  wire [2:0]  mode_code  = display_mode_reg[POS_DISPLAY_MODE +: 3];
  wire [1:0]  src_sel    = clock_ctrl_reg[POS_SOURCE_SEL +: 2];
  wire [1:0]  scan_sel   = clock_ctrl_reg[POS_SCAN_DIV +: 2];

  // slice count and bias from the mode code; others are prohibited
  logic [1:0] last_slice;
  logic       mode_legal;
  logic       mode_third;
  always_comb
  begin
    last_slice = 2'd0;
    mode_legal = 1'b1;
    mode_third = 1'b0;
    case (mode_code)
      MODE_4SLICE_THIRD:
      begin
        last_slice = 2'd3;
        mode_third = 1'b1;
      end
      MODE_3SLICE_THIRD:
      begin
        last_slice = 2'd2;
        mode_third = 1'b1;
      end
      MODE_2SLICE_HALF:  last_slice = 2'd1;
      MODE_3SLICE_HALF:  last_slice = 2'd2;
      MODE_STATIC:       last_slice = 2'd0;
      default:           mode_legal = 1'b0;
    endcase
  end
  wire is_static = (mode_code == MODE_STATIC);

  // source clock tick
  wire xt_rise = (xt_sync_reg[2] == xt_sync_reg[1]) &&
                 xt_sync_reg[1] && !xt_level_reg;
  logic src_tick;
  always_comb
  begin
    case (src_sel)
      SRC_MAIN_DIV128: src_tick = (main_cnt_reg == MAIN_DIV128_MAX);
      SRC_SUBSYSTEM:   src_tick = xt_rise;
      SRC_MAIN_DIV32:  src_tick =
        ((main_cnt_reg & MAIN_DIV32_MAX) == MAIN_DIV32_MAX);
      SRC_MAIN_DIV8:   src_tick =
        ((main_cnt_reg & MAIN_DIV8_MAX) == MAIN_DIV8_MAX);
      default:         src_tick = 1'b0;
    endcase
  end

  // scan clock: source divided by 64 << scan_sel, counter top 63..511
  wire [11:0] pre_top  = {SCAN_DIV64_MAX, 3'h7};
  wire [8:0]  pre_max  = 9'(pre_top >> (2'h3 - scan_sel));
  wire       lcd_tick = src_tick && (pre_cnt_reg == pre_max);
  wire       slice_wrap = (slice_reg >= last_slice);

  // next drive codes
  wire [3:0] com_next = !(display_on && mode_legal) ? 4'h0 :
                        is_static ? 4'hF :
                        4'(4'h1 << slice_reg);
  logic [SEG_COUNT-1:0] seg_next;
  always_comb
  begin
    for (int i = 0; i < SEG_COUNT; i++)
      seg_next[i] = display_on && mode_legal &&
                    disp_mem[i][slice_reg];
  end

  // control registers with bit or byte writes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      display_mode_reg <= RST_DISPLAY_MODE;
      pin_selector_reg <= RST_PIN_SELECTOR;
      clock_ctrl_reg   <= RST_CLOCK_CTRL;
    end
    else if (cpu_wr)
    begin
      if (sel_mode)
        display_mode_reg <= merge(display_mode_reg, cpu_wdata, cpu_wmask,
                                  MASK_DISPLAY_MODE);
      if (sel_pins)
        pin_selector_reg <= merge(pin_selector_reg, cpu_wdata, cpu_wmask,
                                  MASK_PIN_SELECTOR);
      if (sel_clock)
        clock_ctrl_reg   <= merge(clock_ctrl_reg, cpu_wdata, cpu_wmask,
                                  MASK_CLOCK_CTRL);
    end
  end

  // display memory, low nibble only, every bit plain RAM to the cpu
  always_ff @(posedge mclk)
  begin
    if (cpu_wr && sel_mem)
      disp_mem[mem_index] <= 4'(merge({4'h0, disp_mem[mem_index]},
                                      cpu_wdata, cpu_wmask,
                                      MASK_DISP_MEM));
  end

  // read data, one cycle after the read strobe
  wire [7:0] rd_mux = sel_mode  ? display_mode_reg :
                      sel_pins  ? pin_selector_reg :
                      sel_clock ? clock_ctrl_reg :
                      sel_mem   ? {4'h0, disp_mem[mem_index]} :
                      8'h00;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end
    else
    begin
      rdata_reg <= cpu_rd ? rd_mux : 8'h00;
      hit_reg   <= (cpu_rd | cpu_wr) & any_sel;
    end
  end

  // subsystem clock synchroniser and settled level
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xt_sync_reg  <= 3'b000;
      xt_level_reg <= 1'b0;
    end
    else
    begin
      xt_sync_reg <= {xt_sync_reg[1:0], subsystem_oscillator_clock};
      if (xt_sync_reg[2] == xt_sync_reg[1])
        xt_level_reg <= xt_sync_reg[1];
    end
  end

  // main prescaler and scan divider
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      main_cnt_reg <= 7'h00;
      pre_cnt_reg  <= 9'h000;
    end
    else
    begin
      main_cnt_reg <= main_cnt_reg + 7'h01;
      if (lcd_tick)
        pre_cnt_reg <= 9'h000;
      else if (src_tick)
        pre_cnt_reg <= pre_cnt_reg + 9'h001;
    end
  end

  // slice counter and frame polarity
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slice_reg    <= 2'd0;
      polarity_reg <= 1'b0;
    end
    else if (!mode_legal)
      slice_reg <= 2'd0;
    else if (lcd_tick)
    begin
      slice_reg <= slice_wrap ? 2'd0 : slice_reg + 2'd1;
      if (slice_wrap)
        polarity_reg <= ~polarity_reg;
    end
  end

  // registered drive codes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      com_reg <= 4'h0;
      seg_reg <= '0;
    end
    else
    begin
      com_reg <= com_next;
      seg_reg <= seg_next;
    end
  end

  // outputs
  assign cpu_rdata          = rdata_reg;
  assign cpu_hit            = hit_reg;
  assign common_select      = com_reg;
  assign segment_select     = seg_reg;
  assign drive_polarity     = polarity_reg;
  assign bias_third         = mode_third;
  assign static_drive       = is_static;
  assign low_voltage_mode   = display_mode_reg[BIT_LOW_VOLTAGE];
  assign bias_power_on      = display_mode_reg[BIT_DRIVE_POWER];
  assign segment_pin_enable = pin_selector_reg[5:0];

endmodule
`default_nettype wire

// ---- testbench/lcd_panel_model.sv ----
`default_nettype none
module lcd_panel_model #(
  parameter int SEG_COUNT = 28
)(
  input  wire logic                      mclk,
  input  wire logic [3:0]                common_select,
  input  wire logic [SEG_COUNT-1:0]      segment_select,
  input  wire logic                      drive_polarity,
  output var  logic [3:0][SEG_COUNT-1:0] lit,
  output var  int                        frames
);
  logic pol_q   = 1'b0;
  int   count_q = 0;
  // frame count seen by the bench
  assign frames = count_q;
  // a pixel row follows the segments while its common is selected
  always @(posedge mclk)
    for (int k = 0; k < 4; k++)
      if (common_select[k])
        lit[k] <= segment_select;
  // each polarity flip marks a new frame of the ac drive
  always @(posedge mclk)
  begin
    pol_q <= drive_polarity;
    if (pol_q !== drive_polarity)
      count_q <= count_q + 1;
  end
endmodule
`default_nettype wire

// ---- testbench/lcd_seg_monitor.sv ----
`default_nettype none
module lcd_seg_monitor
  import lcd_seg_pkg::*;
#(
  parameter int SEG_COUNT = 28
)(
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic [15:0]          cpu_addr,
  input wire logic [7:0]           cpu_wdata,
  input wire logic [7:0]           cpu_wmask,
  input wire logic                 cpu_wr,
  input wire logic                 cpu_rd,
  input wire logic [7:0]           cpu_rdata,
  input wire logic                 cpu_hit,
  input wire logic [3:0]           common_select,
  input wire logic [SEG_COUNT-1:0] segment_select,
  input wire logic                 static_drive,
  input wire logic                 low_voltage_mode,
  input wire logic                 bias_power_on,
  input wire logic [5:0]           segment_pin_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // address decode of bus accesses
  wire logic acc    = cpu_wr || cpu_rd;
  wire logic mode_a = cpu_addr == ADDR_DISPLAY_MODE;
  wire logic pin_a  = cpu_addr == ADDR_PIN_SELECTOR;
  wire logic clk_a  = cpu_addr == ADDR_CLOCK_CTRL;
  wire logic mem_a  = cpu_addr >= ADDR_DISP_MEM_LO
                      && cpu_addr <= ADDR_DISP_MEM_HI;
  wire logic mapped = mode_a || pin_a || clk_a || mem_a;
  hit_mapped_a: assert property (acc && mapped |=> cpu_hit)
    else $error("no hit on mapped access");
  hit_unmapped_a: assert property (acc && !mapped |=> !cpu_hit)
    else $error("hit on unmapped access");
  rdata_idle_a: assert property (!cpu_rd |=> cpu_rdata == 8'h00)
    else $error("read data without read");
  power_bit_a: assert property (cpu_wr && mode_a && cpu_wmask[4]
    |=> bias_power_on == $past(cpu_wdata[4])) else $error("power bit");
  low_volt_a: assert property (cpu_wr && mode_a && cpu_wmask[6]
    |=> low_voltage_mode == $past(cpu_wdata[6])) else $error("mode bit");
  pin_write_a: assert property (cpu_wr && pin_a && cpu_wmask == 8'hFF
    |=> segment_pin_enable == 6'($past(cpu_wdata))) else $error("pins");
  pin_read_a: assert property (cpu_rd && !cpu_wr && pin_a
    |=> cpu_rdata == {2'h0, segment_pin_enable}) else $error("pin read");
  nibble_read_a: assert property (cpu_rd && (clk_a || mem_a)
    |=> cpu_rdata[7:4] == 4'h0) else $error("upper nibble");
  common_shape_a: assert property ($onehot0(common_select)
    || common_select == 4'hF) else $error("common code");
  blank_seg_a: assert property (common_select == 4'h0
    |-> segment_select == '0) else $error("segments while blank");
  cover property (static_drive && common_select == 4'hF);
  cover property (common_select == 4'h8);
  cover property (cpu_rd ##1 cpu_hit);
endmodule
bind lcd_segment_controller lcd_seg_monitor #(.SEG_COUNT(SEG_COUNT))
  lcd_seg_monitor_inst (.mclk, .arst_n, .cpu_addr, .cpu_wdata, .cpu_wmask,
  .cpu_wr, .cpu_rd, .cpu_rdata, .cpu_hit, .common_select, .segment_select,
  .static_drive, .low_voltage_mode, .bias_power_on, .segment_pin_enable);
`default_nettype wire

// ---- testbench/lcd_segment_controller_tb_top.sv ----
`default_nettype none
module lcd_segment_controller_tb_top
  import lcd_seg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [15:0] a; logic [7:0] d, m, e; logic h;} row_t;
  // address, data, mask, readback, hit
  localparam row_t ROWS [9] = '{'{16'hFFB0, 8'hBF, 8'hFF, 8'h97, 1'b1},
    '{16'hFFB0, 8'h00, 8'hFF, 8'h00, 1'b1},
    '{16'hFFB1, 8'h3F, 8'hFF, 8'h3F, 1'b1},
    '{16'hFFB1, 8'h00, 8'h01, 8'h3E, 1'b1},
    '{16'hFFB2, 8'h0F, 8'hFF, 8'h0F, 1'b1},
    '{16'hFFB2, 8'h00, 8'h04, 8'h0B, 1'b1},
    '{16'hFA1B, 8'h05, 8'hFF, 8'h05, 1'b1},
    '{16'hFA1B, 8'h02, 8'h02, 8'h07, 1'b1},
    '{16'hFA1C, 8'h0F, 8'hFF, 8'h00, 1'b0}};
  logic             mclk = 0, arst_n = 0, cpu_wr = 0, cpu_rd = 0, sub_clk = 0;
  logic [15:0]      cpu_addr = '0;
  logic [7:0]       cpu_wdata = '0, cpu_wmask = '0, cpu_rdata, q;
  logic             cpu_hit, drive_polarity, bias_third, static_drive, h;
  logic             low_voltage_mode, bias_power_on;
  logic [3:0]       common_select;
  logic [27:0]      segment_select;
  logic [5:0]       segment_pin_enable;
  logic [3:0][27:0] lit;
  int               frames, t0, num_errors = 0, compares = 0;
  always #10 mclk = ~mclk;
  always #15259 sub_clk = ~sub_clk;
  lcd_segment_controller lcd_segment_controller_inst (.mclk, .arst_n,
    .cpu_addr, .cpu_wdata, .cpu_wmask, .cpu_wr, .cpu_rd, .cpu_rdata, .cpu_hit,
    .subsystem_oscillator_clock(sub_clk), .common_select, .segment_select,
    .drive_polarity, .bias_third, .static_drive, .low_voltage_mode,
    .bias_power_on, .segment_pin_enable);
  lcd_panel_model lcd_panel_model_inst (.mclk, .common_select,
    .segment_select, .drive_polarity, .lit, .frames);
  task automatic chk(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one bus write or read, driven between rising edges
  task automatic wr(input logic [15:0] a, input logic [7:0] d, m);
    @(negedge mclk);
    {cpu_addr, cpu_wdata, cpu_wmask, cpu_wr} = {a, d, m, 1'b1};
    @(negedge mclk);
    cpu_wr = 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge mclk);
    {cpu_addr, cpu_rd} = {a, 1'b1};
    @(negedge mclk);
    {cpu_rd, q, h} = {1'b0, cpu_rdata, cpu_hit};
  endtask
  // bounded waits on a frame flip or a common code
  task automatic wait_pol(input int n);
    int i;
    int f;
    f = frames;
    for (i = 0; i < n && frames == f; i++)
      @(negedge mclk);
    chk(i < n, 1, "frame timeout");
    if (i == n)
      end_of_test();
  endtask
  task automatic wait_com(input logic [3:0] v);
    int i;
    for (i = 0; i < 600 && common_select !== v; i++)
      @(negedge mclk);
    chk(common_select, v, "common order");
    if (i == 600)
      end_of_test();
  endtask
  // expected pixel row k for the memory pattern
  function automatic logic [27:0] row(input int k);
    logic [3:0] p;
    for (int i = 0; i < 28; i++)
    begin
      p = 4'(i * 7 + 3);
      row[i] = p[k];
    end
  endfunction
  initial
  begin
    repeat (16) @(negedge mclk);
    chk({common_select, segment_select}, 0, "in reset");
    arst_n = 1;
    for (int j = 0; j < 3; j++)
    begin
      rd(ADDR_DISPLAY_MODE + 16'(j));
      chk(q, 8'h00, "reset value");
    end
    foreach (ROWS[r])
    begin
      wr(ROWS[r].a, ROWS[r].d, ROWS[r].m);
      rd(ROWS[r].a);
      chk({q, h}, {ROWS[r].e, ROWS[r].h}, "row");
    end
    for (int m = 0; m < 5; m++)
    begin
      wr(ADDR_DISPLAY_MODE, 8'(m), 8'hFF);
      chk({bias_third, static_drive}, {m < 2, m == 4}, "mode");
    end
    for (int i = 0; i < 28; i++)
      wr(ADDR_DISP_MEM_LO + 16'(i), {4'h0, 4'(i * 7 + 3)}, 8'hFF);
    wr(ADDR_PIN_SELECTOR, 8'h3F, 8'hFF);
    chk(segment_pin_enable, 6'h3F, "pins");
    wr(ADDR_DISPLAY_MODE, 8'h90, 8'hFF);
    wr(ADDR_CLOCK_CTRL, 8'h0C, 8'hFF);
    wait_pol(3000);
    t0 = $time;
    for (int k = 1; k < 4; k++)
      wait_com(4'(1 << k));
    wait_pol(600);
    chk(($time - t0) / 20, 2048, "frame");
    for (int k = 0; k < 4; k++)
      chk(lit[k], row(k), "pixels");
    wr(ADDR_DISPLAY_MODE, 8'h94, 8'hFF);
    wait_pol(2100);
    t0 = $time;
    wait_pol(600);
    chk(($time - t0) / 20, 512, "static frame");
    chk({common_select, lit[3]}, {4'hF, row(0)}, "static");
    // two slices: commons 0 and 1 only, frame of two scan periods
    wr(ADDR_DISPLAY_MODE, 8'h92, 8'hFF);
    wait_pol(2100);
    t0 = $time;
    wait_com(4'h2);
    wait_pol(600);
    chk(($time - t0) / 20, 1024, "two slice frame");
    // slowest scan divider: 512 source ticks of 8 clocks each
    wr(ADDR_DISPLAY_MODE, 8'h94, 8'hFF);
    wr(ADDR_CLOCK_CTRL, 8'h0F, 8'hFF);
    wait_pol(4300);
    t0 = $time;
    wait_pol(4200);
    chk(($time - t0) / 20, 4096, "slow scan");
    wr(ADDR_DISPLAY_MODE, 8'h00, 8'hFF);
    repeat (2) @(negedge mclk);
    chk({common_select, segment_select}, 0, "blank");
    wr(ADDR_DISPLAY_MODE, 8'h40, 8'h40);
    chk({low_voltage_mode, bias_power_on}, 2'b10, "low volt");
    arst_n = 0;
    @(negedge mclk);
    chk({low_voltage_mode, segment_pin_enable}, 0, "reset outs");
    arst_n = 1;
    rd(ADDR_CLOCK_CTRL);
    chk(q, 8'h00, "reset clock");
    end_of_test();
  end
endmodule
`default_nettype wire
